// File: inc/mals_pkg.sv
// Constants shared by the mirror array load and switch block.
package mals_pkg;
    localparam int MALS_ROWS  = 608;
    localparam int MALS_COLS  = 684;
    localparam int MALS_DW    = 15;
    localparam int MALS_WPR   = (MALS_COLS + MALS_DW - 1) / MALS_DW;
    localparam int MALS_WORDS = MALS_ROWS * MALS_WPR;
    localparam int MALS_AW    = 15;
    localparam int MALS_RW    = 10;
    localparam int MALS_CW    = 6;
    localparam int MALS_SYNCW = 35;
    localparam logic [3:0] MALS_CMD_ROW  = 4'h1;
    localparam logic [3:0] MALS_CMD_ALL  = 4'h2;
    localparam logic [3:0] MALS_CMD_PARK = 4'h3;
    localparam logic [1:0] MALS_FIFO_RST = 2'h0;
    localparam logic       MALS_PARK_RST = 1'b1;
    typedef enum logic [1:0] {MALS_SW_IDLE = 2'b00, MALS_SW_COPY = 2'b01} mals_sw_e;
endpackage : mals_pkg

// File: src/mals_top.sv
// Mirror array cell store: double-data-rate loading and commanded mirror switching.
`timescale 1ns/100ps
// Notes on behaviour
// - One stored bit per mirror, 608 by 684.
// - Mirror bit one is ON, zero is OFF.
// - Cells loaded over the fifteen-bit DDR interface.
// - Loading keeps pace with full-array refresh rate except while a switch copy stalls the two-entry buffer.
// - Mirrors change only on switch commands.
// - Toggle rate control sampled on both edges.
// - Load strobe taken low at rising edge.
module mals_top
    import mals_pkg::*;
(
    input  wire logic               mclk_i,
    input  wire logic               reset_i,
    input  wire logic               load_data_clock_i,
    input  wire logic [MALS_DW-1:0] load_data_i,
    input  wire logic               load_strobe_n_i,
    input  wire logic               serial_control_line_i,
    input  wire logic               toggle_rate_control_i,
    input  wire logic [3:0]         mirror_driver_bus_i,
    input  wire logic               mirror_switch_strobe_i,
    input  wire logic [MALS_RW-1:0] stepped_address_bus_i,
    input  wire logic               stepped_address_clock_i,
    input  wire logic [MALS_AW-1:0] inspect_addr_i,
    output logic      [MALS_DW-1:0] mirror_on_o,
    output logic                    mirror_parked_o,
    output logic                    switch_busy_o,
    output logic                    overflow_o
);
    logic [MALS_SYNCW-1:0] sync1_r;
    logic [MALS_SYNCW-1:0] sync2_r;
    logic                  lclk_d_r;
    logic                  sclk_d_r;
    logic                  sws_d_r;
    logic                  lclk_s, strobe_n_s, scl_s, trc_s, sclk_s, sws_s;
    logic [MALS_DW-1:0]    data_s;
    logic [MALS_RW-1:0]    sab_s;
    logic [3:0]            drv_s;
    logic                  rise, fall, edge_any;

    // Every load and command pin passes two flops; the clock and its data share the same delay.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {load_data_clock_i, load_strobe_n_i, serial_control_line_i, toggle_rate_control_i,
                        load_data_i, stepped_address_clock_i, stepped_address_bus_i,
                        mirror_switch_strobe_i, mirror_driver_bus_i};
            sync2_r <= sync1_r;
        end
    end
    assign {lclk_s, strobe_n_s, scl_s, trc_s, data_s, sclk_s, sab_s, sws_s, drv_s} = sync2_r;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            lclk_d_r <= 1'b0;
            sclk_d_r <= 1'b0;
            sws_d_r  <= 1'b0;
        end else begin
            lclk_d_r <= lclk_s;
            sclk_d_r <= sclk_s;
            sws_d_r  <= sws_s;
        end
    end
    assign rise     = lclk_s & ~lclk_d_r;
    assign fall     = ~lclk_s & lclk_d_r;
    assign edge_any = rise | fall;

    // Load sequencer: a strobe opens one row of words, each clock edge carries one word.
    logic               loading_r;
    logic [MALS_CW-1:0] col_r;
    logic [MALS_RW-1:0] row_r;
    logic [MALS_AW-1:0] waddr_r;
    logic               start, push, push_ok, pop, fifo_rdy;
    logic [MALS_DW-1:0] push_word;
    logic [MALS_AW-1:0] push_addr;

    assign start = rise & ~strobe_n_s;
    assign push  = start | (loading_r & edge_any);
    assign push_word = trc_s ? ~data_s : data_s;
    assign push_addr = start ? (scl_s ? '0 : MALS_AW'(row_r * MALS_WPR)) : waddr_r;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            loading_r <= 1'b0;
            col_r     <= '0;
            row_r     <= '0;
            waddr_r   <= '0;
        end else if (push) begin
            waddr_r <= push_addr + MALS_AW'(1);
            if (col_r == MALS_CW'(MALS_WPR - 1)) begin
                loading_r <= 1'b0;
                col_r     <= '0;
                row_r     <= (row_r == MALS_RW'(MALS_ROWS - 1)) ? '0 : row_r + MALS_RW'(1);
            end else begin
                loading_r <= 1'b1;
                col_r     <= start ? MALS_CW'(1) : col_r + MALS_CW'(1);
                if (start && scl_s) begin
                    row_r <= '0;
                end
            end
        end
    end

    // Two-entry buffer between the link edges and the cell store; a switch copy stalls it.
    logic [MALS_DW-1:0] f_dat_r [2];
    logic [MALS_AW-1:0] f_adr_r [2];
    logic [1:0]         f_cnt_r;
    logic               f_wi;
    logic               copying;
    assign fifo_rdy = (f_cnt_r != 2'h2);
    assign push_ok  = push & fifo_rdy;
    assign pop      = (f_cnt_r != 2'h0) & ~copying;
    // The new word lands in slot one only when one entry stays behind.
    assign f_wi     = (f_cnt_r == 2'h1) && !pop;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            f_cnt_r <= MALS_FIFO_RST;
        end else begin
            f_cnt_r <= f_cnt_r + {1'b0, push_ok} - {1'b0, pop};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (pop) begin
            f_dat_r[0] <= f_dat_r[1];
            f_adr_r[0] <= f_adr_r[1];
        end
        if (push_ok) begin
            f_dat_r[f_wi] <= push_word;
            f_adr_r[f_wi] <= push_addr;
        end
    end

    // Sticky: a lost word cannot be recovered, only reported.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            overflow_o <= 1'b0;
        end else if (push && !fifo_rdy) begin
            overflow_o <= 1'b1;
        end
    end

    logic [MALS_DW-1:0] cell_mem   [MALS_WORDS];
    logic [MALS_DW-1:0] mirror_mem [MALS_WORDS];
    always_ff @(posedge mclk_i) begin
        if (pop) begin
            cell_mem[f_adr_r[0]] <= f_dat_r[0];
        end
    end

    // Switch sequencer copies loaded cells into the mirror state, a row or the whole array.
    mals_sw_e           sw_r;
    logic [MALS_AW-1:0] cptr_r;
    logic [MALS_AW-1:0] cend_r;
    logic [MALS_RW-1:0] srow_r;
    logic               sw_cmd;
    assign copying = (sw_r == MALS_SW_COPY);
    assign sw_cmd  = sws_s & ~sws_d_r;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            srow_r <= '0;
        end else if (sclk_s && !sclk_d_r) begin
            srow_r <= (sab_s < MALS_RW'(MALS_ROWS)) ? sab_s : srow_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sw_r   <= MALS_SW_IDLE;
            cptr_r <= '0;
            cend_r <= '0;
        end else begin
            case (sw_r)
                MALS_SW_IDLE: begin
                    if (sw_cmd && drv_s == MALS_CMD_ROW) begin
                        sw_r   <= MALS_SW_COPY;
                        cptr_r <= MALS_AW'(srow_r * MALS_WPR);
                        cend_r <= MALS_AW'(srow_r * MALS_WPR + MALS_WPR - 1);
                    end else if (sw_cmd && drv_s == MALS_CMD_ALL) begin
                        sw_r   <= MALS_SW_COPY;
                        cptr_r <= '0;
                        cend_r <= MALS_AW'(MALS_WORDS - 1);
                    end
                end
                MALS_SW_COPY: begin
                    cptr_r <= cptr_r + MALS_AW'(1);
                    if (cptr_r == cend_r) begin
                        sw_r <= MALS_SW_IDLE;
                    end
                end
                default: sw_r <= MALS_SW_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (copying) begin
            mirror_mem[cptr_r] <= cell_mem[cptr_r];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mirror_parked_o <= MALS_PARK_RST;
        end else if (sw_cmd && sw_r == MALS_SW_IDLE) begin
            if (drv_s == MALS_CMD_PARK) begin
                mirror_parked_o <= 1'b1;
            end else if (drv_s == MALS_CMD_ROW || drv_s == MALS_CMD_ALL) begin
                mirror_parked_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            switch_busy_o <= 1'b0;
            mirror_on_o   <= '0;
        end else begin
            switch_busy_o <= copying;
            mirror_on_o   <= mirror_parked_o ? '0 : mirror_mem[inspect_addr_i];
        end
    end

    a_strobe_start: assert property (@(posedge mclk_i) disable iff (reset_i)
        start |=> (loading_r && col_r == MALS_CW'(1))) else $error("load start did not open a row");
    a_ddr_push: assert property (@(posedge mclk_i) disable iff (reset_i)
        (loading_r && fall) |=> (waddr_r == $past(waddr_r) + MALS_AW'(1))) else $error("falling edge word not taken");
    a_trc_invert: assert property (@(posedge mclk_i) disable iff (reset_i)
        (push_ok && trc_s && f_cnt_r == 2'h0) |=> (f_dat_r[0] == ~$past(data_s))) else $error("toggle rate not applied");
    a_row_words: assert property (@(posedge mclk_i) disable iff (reset_i)
        (push && !start && col_r == MALS_CW'(MALS_WPR - 1)) |=> !loading_r) else $error("row length wrong");
    a_cell_addr: assert property (@(posedge mclk_i) disable iff (reset_i)
        push |-> (push_addr < MALS_AW'(MALS_WORDS))) else $error("cell address out of array");
    a_drain_rate: assert property (@(posedge mclk_i) disable iff (reset_i)
        (!copying && f_cnt_r != 2'h0) |=> (f_cnt_r != 2'h2) || $past(push_ok))
        else $error("buffer not drained");
    a_copy_cmd: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(copying) |-> $past(sw_cmd)) else $error("mirrors moved without command");
    a_park_dark: assert property (@(posedge mclk_i) disable iff (reset_i)
        (mirror_parked_o && $past(mirror_parked_o)) |=> (mirror_on_o == '0)) else $error("parked mirror shows ON");
    c_row_load: cover property (@(posedge mclk_i) disable iff (reset_i) start ##[1:400] !loading_r);
    c_switch_all: cover property (@(posedge mclk_i) disable iff (reset_i) sw_cmd && drv_s == MALS_CMD_ALL);
    c_park: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(mirror_parked_o));
    c_fifo_full: cover property (@(posedge mclk_i) disable iff (reset_i) f_cnt_r == 2'h2);
endmodule : mals_top

// File: dv/mals_ctrl_model.sv
// Display controller model driving the load link and mirror commands.
`timescale 1ns/100ps
module mals_ctrl_model
    import mals_pkg::*;
(
    input  wire logic               mclk_i,
    output logic                    load_data_clock_o,
    output logic      [MALS_DW-1:0] load_data_o,
    output logic                    load_strobe_n_o,
    output logic                    serial_control_line_o,
    output logic                    toggle_rate_control_o,
    output logic      [3:0]         mirror_driver_bus_o,
    output logic                    mirror_switch_strobe_o,
    output logic      [MALS_RW-1:0] stepped_address_bus_o,
    output logic                    stepped_address_clock_o
);
    initial begin
        {load_data_clock_o, load_data_o, serial_control_line_o, toggle_rate_control_o} = '0;
        {mirror_driver_bus_o, mirror_switch_strobe_o, stepped_address_bus_o, stepped_address_clock_o} = '0;
        load_strobe_n_o = 1'b1;
    end

    function automatic logic [MALS_DW-1:0] pat(input int row, input int col, input logic flip);
        return MALS_DW'(col * 523 + row * 77 + 165) ^ {MALS_DW{flip}};
    endfunction : pat

    // strobe with the first of 46 words on both edges
    task automatic load_row(input int row, input logic restart, input logic flip);
        for (int c = 0; c < MALS_WPR; c++) begin
            load_data_o           = pat(row, c, flip);
            toggle_rate_control_o = (c % 3 == 0);
            load_strobe_n_o       = (c != 0);
            serial_control_line_o = restart && (c == 0);
            #12;
            load_data_clock_o = ~load_data_clock_o;
            #12;
        end
        // Released lines go to the inverse so a stale value never reads as valid.
        load_data_o           = ~load_data_o;
        toggle_rate_control_o = ~toggle_rate_control_o;
        // The gap keeps a following row from driving the same lines in this time step.
        #24;
    endtask : load_row

    // commands issued only from the controller side
    task automatic send_cmd(input logic [3:0] code, input int row);
        @(negedge mclk_i);
        stepped_address_bus_o = MALS_RW'(row);
        mirror_driver_bus_o   = code;
        repeat (4) @(negedge mclk_i);
        stepped_address_clock_o = 1'b1;
        repeat (4) @(negedge mclk_i);
        mirror_switch_strobe_o = 1'b1;
        repeat (6) @(negedge mclk_i);
        mirror_switch_strobe_o  = 1'b0;
        stepped_address_clock_o = 1'b0;
    endtask : send_cmd
endmodule : mals_ctrl_model

// File: dv/mals_top_test.sv
// Self-checking bench for the mirror array load and switch block.
`timescale 1ns/100ps
module mals_top_test;
    import mals_pkg::*;
    logic               mclk_i;
    logic               reset_i;
    logic [MALS_AW-1:0] inspect_addr_i;
    logic               ldc, lsn, scl, toggle_rate_control, sw_stb, sac;
    logic [MALS_DW-1:0] ldata, mirror_on_o;
    logic [3:0]         mdb;
    logic [MALS_RW-1:0] sab;
    logic               mirror_parked_o, switch_busy_o, overflow_o;
    int                 n_fail = 0;
    int                 comparisons = 0;

    mals_ctrl_model ctl (.mclk_i(mclk_i), .load_data_clock_o(ldc), .load_data_o(ldata), .load_strobe_n_o(lsn),
        .serial_control_line_o(scl), .toggle_rate_control_o(toggle_rate_control), .mirror_driver_bus_o(mdb),
        .mirror_switch_strobe_o(sw_stb), .stepped_address_bus_o(sab), .stepped_address_clock_o(sac));
    mals_top uut (.mclk_i(mclk_i), .reset_i(reset_i), .load_data_clock_i(ldc), .load_data_i(ldata),
        .load_strobe_n_i(lsn), .serial_control_line_i(scl), .toggle_rate_control_i(toggle_rate_control),
        .mirror_driver_bus_i(mdb), .mirror_switch_strobe_i(sw_stb), .stepped_address_bus_i(sab),
        .stepped_address_clock_i(sac), .inspect_addr_i(inspect_addr_i), .mirror_on_o(mirror_on_o),
        .mirror_parked_o(mirror_parked_o), .switch_busy_o(switch_busy_o), .overflow_o(overflow_o));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic check(input logic [MALS_DW-1:0] seen, input logic [MALS_DW-1:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // The copy of the whole array is long, so the bound covers it with margin.
    task automatic wait_idle();
        int n;
        n = 0;
        while (switch_busy_o !== 1'b0 && n < 30000) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= 30000) begin
            n_fail++;
            end_sim();
        end else begin
            repeat (2) @(negedge mclk_i);
        end
    endtask : wait_idle

    task automatic check_row(input int row, input logic flip);
        logic [MALS_DW-1:0] exp, m;
        for (int c = 0; c < MALS_WPR; c++) begin
            inspect_addr_i = MALS_AW'(row * MALS_WPR + c);
            @(negedge mclk_i);
            exp = ctl.pat(row, c, flip) ^ {MALS_DW{c % 3 == 0}};
            // Only nine columns of the last word hold mirrors.
            m = (c == MALS_WPR - 1) ? 15'h01ff : 15'h7fff;
            check(mirror_on_o & m, exp & m, "mirror word");
        end
    endtask : check_row

    task automatic cmd(input logic [3:0] code, input int row);
        ctl.send_cmd(code, row);
        check({14'h0, switch_busy_o}, {14'h0, (code == MALS_CMD_ROW) || (code == MALS_CMD_ALL)}, "busy");
        wait_idle();
    endtask : cmd

    task automatic test_reset();
        check(mirror_on_o, 15'h0000, "mirrors at reset");
        check({12'h0, mirror_parked_o, switch_busy_o, overflow_o}, 15'h0004, "flags at reset");
        $display("test_reset done");
    endtask : test_reset

    task automatic test_rows();
        ctl.load_row(0, 1'b1, 1'b0);
        ctl.load_row(1, 1'b0, 1'b0);
        cmd(MALS_CMD_ROW, 0);
        check({14'h0, mirror_parked_o}, 15'h0000, "unparked");
        check_row(0, 1'b0);
        cmd(MALS_CMD_ROW, 1);
        check_row(1, 1'b0);
        $display("test_rows done");
    endtask : test_rows

    task automatic test_hold();
        ctl.load_row(0, 1'b1, 1'b1);
        repeat (20) @(negedge mclk_i);
        check_row(0, 1'b0);
        cmd(4'h0, 0);
        check_row(0, 1'b0);
        cmd(MALS_CMD_ROW, 0);
        check_row(0, 1'b1);
        $display("test_hold done");
    endtask : test_hold

    task automatic test_park();
        cmd(MALS_CMD_PARK, 0);
        check({14'h0, mirror_parked_o}, 15'h0001, "parked");
        check(mirror_on_o, 15'h0000, "parked mirrors");
        cmd(MALS_CMD_ROW, 1);
        check_row(1, 1'b0);
        $display("test_park done");
    endtask : test_park

    task automatic test_overflow();
        ctl.send_cmd(MALS_CMD_ALL, 0);
        ctl.load_row(0, 1'b1, 1'b0);
        check({14'h0, switch_busy_o}, 15'h0001, "still copying");
        check({14'h0, overflow_o}, 15'h0001, "word lost");
        wait_idle();
        check({14'h0, overflow_o}, 15'h0001, "sticky loss");
        $display("test_overflow done");
    endtask : test_overflow

    initial begin
        reset_i = 1'b1;
        inspect_addr_i = '0;
        repeat (20) @(negedge mclk_i);
        test_reset();
        reset_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        test_rows();
        test_hold();
        test_park();
        test_overflow();
        end_sim();
    end
endmodule : mals_top_test
